/* File: hw/pbs_access.sv */
// Functional notes
// [RULE_01] Inputs go through input registers; read data through output registers.
// [RULE_02] Clock qualifier high freezes every internal state for that edge; the output enable synchroniser and the lane driver register still update.
// [RULE_03] Selected, qualified and load low at an edge latches the address.
// [RULE_04] Load with write enable high starts a read of the latched address.
// [RULE_05] Read data appears after the next edge via the output register.
// [RULE_06] Read data is driven only while output enable is low.
// [RULE_07] A new command is accepted in the cycle after a read.
// [RULE_08] Deselect at an edge tristates the outputs after the next edge.
// [RULE_09] A burst counter gives up to four accesses per loaded address.
// [RULE_10] Burst order low is linear, high is interleaved.
// [RULE_11] The counter covers the two low address bits and wraps.
// [RULE_12] Advance high steps the counter, ignoring selects and write enable.
// [RULE_13] Direction is captured at burst start and kept for the burst.
// [RULE_14] Load with write enable low starts a write and latches its controls.
// [RULE_15] Edge after a write command tristates data and parity lanes.
// [RULE_16] The cycle after a write accepts the next command.
// [RULE_17] Write data is latched at the second edge after the command.
// [RULE_18] Only selected byte lanes are written; others stay unchanged.
// [RULE_19] Controller should load a fresh address after a deselect.
// [RULE_20] Core holds one million words of 36 bits in four lanes.
// [RULE_21] Reads and writes mix freely, one word every cycle.
// [RULE_22] Controller drives byte lane selects in every burst cycle.
// [RULE_23] After reset the device is deselected with lanes tristated.
// [RULE_24] Linear adds the step modulo four; interleaved XORs it.
// [RULE_25] Drivers on only for a pending read, selected, output enable low.

module pbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wp_r;
   logic [PW-1:0] rp_r;
   logic [PW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = (cnt_r != (PW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (push && !pop) begin
         cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

endmodule : pbs_fifo

module pbs_access (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic NRST,
   // Command inputs
   input wire logic CLOCK_QUALIFY_N,
   input wire logic CHIP_SELECT_FIRST_N,
   input wire logic CHIP_SELECT_SECOND,
   input wire logic CHIP_SELECT_THIRD_N,
   input wire logic ADVANCE_OR_LOAD,
   input wire logic WRITE_ENABLE_N,
   input wire logic [pbs_pkg::LANES-1:0] BYTE_LANE_SELECT_N,
   input wire logic [pbs_pkg::ADDR_W-1:0] ADDRESS,
   input wire logic BURST_ORDER,
   // Asynchronous output enable
   input wire logic OUTPUT_ENABLE_N,
   // Data lanes
   input wire logic [pbs_pkg::DATA_W-1:0] DATA_I,
   output logic [pbs_pkg::DATA_W-1:0] DATA_O,
   output logic DATA_OE_N,
   // Parity lanes
   input wire logic [pbs_pkg::LANES-1:0] PARITY_LANES_I,
   output logic [pbs_pkg::LANES-1:0] PARITY_LANES_O,
   output logic PARITY_LANES_OE_N
);

   // Mask of the bits that the active byte lanes cover
   function automatic pbs_pkg::pbs_word_t lane_mask(
      input logic [pbs_pkg::LANES-1:0] bw_n
   );
      pbs_pkg::pbs_word_t m;
      m = '0;
      for (int k = 0; k < pbs_pkg::LANES; k++) begin
         if (!bw_n[k]) begin
            m[k*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] = '1;
            m[pbs_pkg::DATA_W + k] = 1'b1;
         end
      end
      return m;
   endfunction : lane_mask

   // Merge a pending write into a word when its address matches
   function automatic pbs_pkg::pbs_word_t merge(
      input pbs_pkg::pbs_word_t old,
      input logic hit,
      input pbs_pkg::pbs_wr_s wr
   );
      pbs_pkg::pbs_word_t m;
      m = hit ? lane_mask(wr.bw_n) : '0;
      return (old & ~m) | (wr.data & m);
   endfunction : merge

   // Low address bits for a burst step
   function automatic logic [1:0] burst_lo(
      input logic [1:0] base,
      input logic [1:0] step,
      input logic inter
   );
      return inter ? (base ^ step) : 2'(base + step); // RULE_24 RULE_10
   endfunction : burst_lo

   logic go;
   logic in_sel_r;
   logic in_adv_r;
   logic in_we_n_r;
   logic [pbs_pkg::LANES-1:0] in_bw_n_r;
   logic [pbs_pkg::ADDR_W-1:0] in_addr_r;
   logic in_order_r;
   pbs_pkg::pbs_word_t in_data_r;
   logic act_r;
   pbs_pkg::pbs_op_e dir_r;
   logic [pbs_pkg::ADDR_W-1:0] base_r;
   logic [pbs_pkg::BURST_W-1:0] step_r;
   logic ord_r;
   logic [pbs_pkg::BURST_W-1:0] step_nxt;
   pbs_pkg::pbs_cmd_s cmd_nxt;
   pbs_pkg::pbs_cmd_s wr1_r;
   pbs_pkg::pbs_cmd_s wr2_r;
   pbs_pkg::pbs_wr_s pend;
   logic pend_vld;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [pbs_pkg::WR_W-1:0] fifo_out_data;
   pbs_pkg::pbs_wr_s head;
   pbs_pkg::pbs_word_t core_r [pbs_pkg::WORDS];
   pbs_pkg::pbs_word_t rd_word;
   pbs_pkg::pbs_word_t out_r;
   logic rd_vld_r;
   logic rd_vld_nxt;
   logic oe_s1_r;
   logic oe_s2_r;
   logic drive_n_r;

   // Qualifier high means the edge does not count
   assign go = ~CLOCK_QUALIFY_N; // RULE_02

   // Input registers
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         in_sel_r <= 1'b0;
         in_adv_r <= 1'b0;
         in_we_n_r <= 1'b1;
         in_bw_n_r <= pbs_pkg::BW_N_RST;
         in_addr_r <= '0;
         in_order_r <= 1'b0;
         in_data_r <= '0;
      end else if (go) begin // RULE_02
         in_sel_r <= ~CHIP_SELECT_FIRST_N & CHIP_SELECT_SECOND & ~CHIP_SELECT_THIRD_N; // RULE_01
         in_adv_r <= ADVANCE_OR_LOAD;
         in_we_n_r <= WRITE_ENABLE_N;
         in_bw_n_r <= BYTE_LANE_SELECT_N;
         in_addr_r <= ADDRESS;
         in_order_r <= BURST_ORDER;
         in_data_r <= {PARITY_LANES_I, DATA_I}; // RULE_17
      end
   end

   // Command decode from the registered inputs
   always_comb begin
      cmd_nxt.op = pbs_pkg::OP_IDLE;
      cmd_nxt.addr = in_addr_r;
      cmd_nxt.bw_n = in_bw_n_r;
      step_nxt = pbs_pkg::BURST_FIRST;
      if (!in_adv_r) begin
         if (in_sel_r) begin // RULE_03 RULE_08
            cmd_nxt.op = in_we_n_r ? pbs_pkg::OP_READ : pbs_pkg::OP_WRITE; // RULE_04 RULE_14
         end
      end else begin
         step_nxt = 2'(step_r + pbs_pkg::BURST_STEP); // RULE_09 RULE_11 RULE_12
         cmd_nxt.addr = {base_r[pbs_pkg::ADDR_W-1:2], burst_lo(base_r[1:0], step_nxt, ord_r)};
         cmd_nxt.op = act_r ? dir_r : pbs_pkg::OP_IDLE; // RULE_13 RULE_19
      end
   end

   // Burst state
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         act_r <= 1'b0; // RULE_23
         dir_r <= pbs_pkg::OP_IDLE;
         base_r <= '0;
         step_r <= pbs_pkg::BURST_FIRST;
         ord_r <= 1'b0;
      end else if (go) begin
         step_r <= step_nxt;
         if (!in_adv_r) begin
            act_r <= in_sel_r; // RULE_08
            dir_r <= cmd_nxt.op; // RULE_13
            base_r <= in_addr_r; // RULE_03
            ord_r <= in_order_r; // RULE_10
         end
      end
   end

   // Write pipeline: controls now, data two edges later
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         wr1_r.op <= pbs_pkg::OP_IDLE;
         wr1_r.addr <= '0;
         wr1_r.bw_n <= pbs_pkg::BW_N_RST;
         wr2_r.op <= pbs_pkg::OP_IDLE;
         wr2_r.addr <= '0;
         wr2_r.bw_n <= pbs_pkg::BW_N_RST;
      end else if (go) begin
         wr1_r <= cmd_nxt; // RULE_14 RULE_16
         wr2_r <= wr1_r; // RULE_17
      end
   end

   assign pend_vld = (wr2_r.op == pbs_pkg::OP_WRITE);
   assign pend.addr = wr2_r.addr;
   assign pend.bw_n = wr2_r.bw_n;
   assign pend.data = in_data_r;

   // Completed writes queue for the core
   pbs_fifo #(
      .WIDTH(pbs_pkg::WR_W),
      .DEPTH(pbs_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clk(CLK_SYS),
      .rst_n(NRST),
      .in_valid(pend_vld & go),
      .in_ready(fifo_in_ready),
      .in_data(pend),
      .out_valid(fifo_out_valid),
      .out_ready(go),
      .out_data(fifo_out_data)
   );

   assign head = pbs_pkg::pbs_wr_s'(fifo_out_data);

   // Core storage, byte lane write
   always_ff @(posedge CLK_SYS) begin
      if (fifo_out_valid && go) begin // RULE_02
         core_r[head.addr] <= merge(core_r[head.addr], 1'b1, head); // RULE_18 RULE_20
      end
   end

   // Read path with forwarding of writes not yet in the core
   always_comb begin
      rd_word = core_r[cmd_nxt.addr];
      rd_word = merge(rd_word, fifo_out_valid && (head.addr == cmd_nxt.addr), head); // RULE_21
      rd_word = merge(rd_word, pend_vld && fifo_in_ready && (pend.addr == cmd_nxt.addr), pend);
   end

   assign rd_vld_nxt = go ? (cmd_nxt.op == pbs_pkg::OP_READ) : rd_vld_r; // RULE_02

   // Output register
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         rd_vld_r <= 1'b0; // RULE_23
         out_r <= '0;
      end else begin
         rd_vld_r <= rd_vld_nxt; // RULE_07 RULE_08 RULE_15
         if (go && cmd_nxt.op == pbs_pkg::OP_READ) begin
            out_r <= rd_word; // RULE_01 RULE_05
         end
      end
   end

   // Output enable pin synchroniser
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         oe_s1_r <= pbs_pkg::OE_N_RST;
         oe_s2_r <= pbs_pkg::OE_N_RST;
      end else begin
         oe_s1_r <= OUTPUT_ENABLE_N;
         oe_s2_r <= oe_s1_r;
      end
   end

   // Lane drivers
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         drive_n_r <= pbs_pkg::DRIVE_N_RST; // RULE_23
      end else begin
         drive_n_r <= ~(rd_vld_nxt & ~oe_s2_r); // RULE_06 RULE_25 RULE_15
      end
   end

   assign DATA_O = out_r[pbs_pkg::DATA_W-1:0];
   assign PARITY_LANES_O = out_r[pbs_pkg::WORD_W-1:pbs_pkg::DATA_W];
   assign DATA_OE_N = drive_n_r;
   assign PARITY_LANES_OE_N = drive_n_r;

endmodule : pbs_access

/* File: hw/pbs_pkg.sv */
package pbs_pkg;

   // Organisation of the core
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int WORD_W = DATA_W + LANES;
   localparam int WORDS = 1 << ADDR_W;

   // Burst
   localparam int BURST_LEN = 4;
   localparam int BURST_W = 2;
   localparam logic [1:0] BURST_STEP = 2'h1;
   localparam logic [1:0] BURST_FIRST = 2'h0;

   // Write FIFO
   localparam int FIFO_DEPTH = 16;

   // Reset values
   localparam logic [LANES-1:0] BW_N_RST = 4'hf;
   localparam logic DRIVE_N_RST = 1'b1;
   localparam logic OE_N_RST = 1'b1;

   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_READ = 2'b01,
      OP_WRITE = 2'b11
   } pbs_op_e;

   typedef logic [WORD_W-1:0] pbs_word_t;

   typedef struct packed {
      pbs_op_e op;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] bw_n;
   } pbs_cmd_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] bw_n;
      pbs_word_t data;
   } pbs_wr_s;

   localparam int WR_W = $bits(pbs_wr_s);

endpackage : pbs_pkg

/* File: verif/pbs_access_chk.sv */
module pbs_access_chk (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic NRST,
   // Command inputs
   input wire logic CLOCK_QUALIFY_N,
   input wire logic CHIP_SELECT_FIRST_N,
   input wire logic CHIP_SELECT_SECOND,
   input wire logic CHIP_SELECT_THIRD_N,
   input wire logic ADVANCE_OR_LOAD,
   input wire logic WRITE_ENABLE_N,
   input wire logic OUTPUT_ENABLE_N,
   // Outputs
   input wire logic [pbs_pkg::DATA_W-1:0] DATA_O,
   input wire logic DATA_OE_N,
   input wire logic PARITY_LANES_OE_N
);
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);
   logic sel;
   logic ld;
   logic rd_adv;
   logic rd_ld;
   logic rd_q_r = 1'h0;
   logic [2:0] oe_lo_r = 3'h0;
   assign sel = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N;
   assign ld = !CLOCK_QUALIFY_N && !ADVANCE_OR_LOAD;
   assign rd_adv = !CLOCK_QUALIFY_N && (ADVANCE_OR_LOAD || sel && WRITE_ENABLE_N);
   assign rd_ld = ld && sel && WRITE_ENABLE_N;
   // Read asked at the last qualified edge
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         rd_q_r <= 1'h0;
      end else if (!CLOCK_QUALIFY_N) begin
         rd_q_r <= rd_adv;
      end
   end
   // Cycles the enable pin has been low, up to four
   always_ff @(posedge CLK_SYS) begin
      if (OUTPUT_ENABLE_N) begin
         oe_lo_r <= 3'h0;
      end else if (oe_lo_r != 3'h4) begin
         oe_lo_r <= oe_lo_r + 3'h1;
      end
   end
   a_wr_tristate: assert property ((ld && sel && !WRITE_ENABLE_N) ##1
      !CLOCK_QUALIFY_N |=> DATA_OE_N) else $error("Drivers on after write");
   a_desel_off: assert property ((ld && !sel) ##1 !CLOCK_QUALIFY_N |=> DATA_OE_N)
      else $error("Drivers on after deselect");
   a_oe_block: assert property (OUTPUT_ENABLE_N [*5] |-> DATA_OE_N)
      else $error("Drivers on with enable pin high");
   a_reset_off: assert property (disable iff (1'h0) !NRST |=> DATA_OE_N)
      else $error("Drivers on after reset");
   a_lanes_pair: assert property (DATA_OE_N == PARITY_LANES_OE_N)
      else $error("Data and parity enables differ");
   a_freeze_hold: assert property (CLOCK_QUALIFY_N |=> $stable(DATA_O))
      else $error("Read data moved on ignored edge");
   a_read_drive: assert property ((rd_ld && oe_lo_r == 3'h4) ##1
      (!CLOCK_QUALIFY_N && !OUTPUT_ENABLE_N) |=> !DATA_OE_N) else $error("Read not driven");
   a_data_cause: assert property ($changed(DATA_O) |->
      $past(!NRST) || $past(!CLOCK_QUALIFY_N) && $past(rd_q_r))
      else $error("Read data moved unasked");
endmodule : pbs_access_chk

/* File: verif/pbs_ctrl_model.sv */
module pbs_ctrl_model (
   // Clock and qualifier
   input wire logic clk,
   input wire logic clock_qualify_n,
   // Write request from the bench
   input wire logic wr_go,
   input wire pbs_pkg::pbs_word_t wr_word,
   // Lines towards the device
   output logic [31:0] data,
   output logic [3:0] par
);
   timeunit 1ns;
   timeprecision 1ps;
   logic s1_r = 1'h0;
   logic s2_r = 1'h0;
   pbs_pkg::pbs_word_t w1_r, w2_r;
   pbs_pkg::pbs_word_t last_r = '0;
   // Two qualified edges from command to data
   always_ff @(posedge clk) begin
      if (!clock_qualify_n) begin
         s1_r <= wr_go;
         w1_r <= wr_word;
         s2_r <= s1_r;
         w2_r <= w1_r;
      end
   end
   always_ff @(posedge clk) begin
      if (s2_r && !clock_qualify_n) begin
         last_r <= w2_r;
      end
   end
   // Released lines show the inverse of the last word
   assign {par, data} = s2_r ? w2_r : ~last_r;
endmodule : pbs_ctrl_model

/* File: verif/pbs_access_tb.sv */
module pbs_access_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, cq_n, cs1_n, cs2, cs3_n, adv, we_n, ord, oe_n, wr_go, doe_n, b_ord, b_wr;
   logic exp_v, poe_n;
   logic [3:0] bw, p_i, p_o;
   logic [19:0] addr, b_base;
   logic [31:0] d_i, d_o;
   logic [1:0] b_n;
   int fail_count, tests_run;
   pbs_pkg::pbs_word_t exp_w, wr_w;
   pbs_pkg::pbs_word_t mem [logic [19:0]];
   logic rv [25];
   pbs_pkg::pbs_word_t rw [25];
   // Row: op (0 idle, 1 read, 2 write, 3 advance), order, lane selects, address
   logic [15:0] rows [23] = '{16'h8010, 16'h8021, 16'hC000, 16'hC000, 16'hC000, 16'h0001,
      16'hA035, 16'hC000, 16'hC000, 16'hC000, 16'h9410, 16'h0002, 16'h4010, 16'h6021,
      16'hC000, 16'hC000, 16'hC000, 16'h4035, 16'hC000, 16'hC000, 16'hC000, 16'h0000, 16'h0000};
   pbs_access u_dut (.CLK_SYS(clk), .NRST(nrst), .CLOCK_QUALIFY_N(cq_n),
      .CHIP_SELECT_FIRST_N(cs1_n), .CHIP_SELECT_SECOND(cs2), .CHIP_SELECT_THIRD_N(cs3_n),
      .ADVANCE_OR_LOAD(adv), .WRITE_ENABLE_N(we_n), .BYTE_LANE_SELECT_N(bw), .ADDRESS(addr),
      .BURST_ORDER(ord), .OUTPUT_ENABLE_N(oe_n), .DATA_I(d_i), .DATA_O(d_o), .DATA_OE_N(doe_n),
      .PARITY_LANES_I(p_i), .PARITY_LANES_O(p_o), .PARITY_LANES_OE_N(poe_n));
   pbs_ctrl_model u_ctrl (.clk(clk), .clock_qualify_n(cq_n), .wr_go(wr_go), .wr_word(wr_w),
      .data(d_i), .par(p_i));
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   task automatic issue(input logic [15:0] r);
      logic [1:0] op;
      logic [19:0] a;
      pbs_pkg::pbs_word_t w;
      op = r[15:14];
      @(posedge clk);
      if (op == 2'h1 || op == 2'h2) begin
         b_base = {12'h000, r[7:0]};
         b_n = 2'h0;
         b_ord = r[13];
         b_wr = op[1];
         addr <= b_base;
         ord <= b_ord;
      end else if (op == 2'h3) begin
         b_n = b_n + 2'h1;
      end
      cs1_n <= op == 2'h3 || op == 2'h0 && r[1:0] == 2'h0;
      cs2 <= !(op == 2'h0 && r[1:0] == 2'h1);
      cs3_n <= op == 2'h0 && r[1:0] == 2'h2;
      adv <= op == 2'h3;
      we_n <= (op == 2'h3) ? b_wr : !b_wr;
      bw <= r[12:9];
      a = {b_base[19:2], b_ord ? b_base[1:0] ^ b_n : b_base[1:0] + b_n};
      w = {a[3:0] ^ r[12:9], 32'hA5C3_0F00 ^ {4{a[7:0] ^ {r[12:9], r[12:9]}}}};
      wr_go <= op != 2'h0 && b_wr;
      wr_w <= w;
      exp_v = op != 2'h0 && !b_wr;
      for (int k = 0; k < 4; k++) begin
         if (op != 2'h0 && b_wr && !r[9+k]) begin
            mem[a][8*k+:8] = w[8*k+:8];
            mem[a][32+k] = w[32+k];
         end
      end
      exp_w = exp_v ? mem[a] : '0;
   endtask : issue
   initial begin
      #3000ns;
      fail_count++;
      test_done();
   end
   initial begin
      nrst = 1'h0;
      cq_n = 1'h0;
      cs1_n = 1'h1;
      cs2 = 1'h1;
      cs3_n = 1'h0;
      adv = 1'h0;
      we_n = 1'h1;
      bw = 4'hf;
      addr = '0;
      ord = 1'h0;
      oe_n = 1'h0;
      wr_go = 1'h0;
      wr_w = '0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      check({34'h0, doe_n, poe_n}, 36'h3);
      @(posedge clk);
      nrst <= 1'h1;
      for (int i = 0; i < 25; i++) begin
         issue(i < 23 ? rows[i] : 16'h0000);
         rv[i] = exp_v;
         rw[i] = exp_w;
         @(negedge clk);
         if (i >= 2 && rv[i-2]) begin
            check({p_o, d_o}, rw[i-2]);
            check({35'h0, doe_n}, 36'h0);
         end
         check({34'h0, doe_n, poe_n}, {34'h0, {2{!(i >= 2 && rv[i-2])}}});
      end
      $display("Test rows done");
      issue(16'h4035);
      cq_n <= 1'h1;
      repeat (3) begin
         @(negedge clk);
         check({p_o, d_o}, mem[20'h0_0034]);
      end
      @(posedge clk);
      cq_n <= 1'h0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({p_o, d_o}, mem[20'h0_0035]);
      $display("Test freeze done");
      @(posedge clk);
      oe_n <= 1'h1;
      repeat (4) issue(16'h4010);
      @(negedge clk);
      check({35'h0, doe_n}, 36'h1);
      check({p_o, d_o}, mem[20'h0_0010]);
      @(posedge clk);
      oe_n <= 1'h0;
      repeat (4) issue(16'h4010);
      @(negedge clk);
      check({35'h0, doe_n}, 36'h0);
      $display("Test enable done");
      @(posedge clk);
      nrst <= 1'h0;
      @(posedge clk);
      @(negedge clk);
      check({35'h0, doe_n}, 36'h1);
      $display("Test reset done");
      test_done();
   end
endmodule : pbs_access_tb

bind pbs_access pbs_access_chk u_chk (.CLK_SYS, .NRST, .CLOCK_QUALIFY_N, .CHIP_SELECT_FIRST_N,
   .CHIP_SELECT_SECOND, .CHIP_SELECT_THIRD_N, .ADVANCE_OR_LOAD, .WRITE_ENABLE_N,
   .OUTPUT_ENABLE_N, .DATA_O, .DATA_OE_N, .PARITY_LANES_OE_N);
